// ==== logic/tsp_fifo.sv ====
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module tsp_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // full and empty straight from the occupancy count
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage has no reset; only words below the count are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers wrap; depth is a power of two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ==== logic/tsp_pkg.sv ====
// constants, register map and types of the transmit symbol pattern block
// What this block does
// - symbol 1 pattern is upper byte at 4Fh joined with lower byte at 50h
// - symbol 2 pattern is the whole byte of register 51h
// - symbol 3 pattern is the whole byte of register 52h
// - bits 7..4 at 53h give symbol 1 valid bits, code plus one
// - bits 3..0 at 53h give symbol 0 valid bits, code plus one
// - bits 6..4 at 54h give symbol 3 valid bits, code plus one
// - bits 2..0 at 54h give symbol 2 valid bits; bits 7 and 3 reserved
// - control bit 4 adds a burst of burst-length plus one bits before symbol 1
// - control bit 0 adds a burst of burst-length plus one bits before symbol 0
// - control bit 5 makes symbol 1 a burst with no pattern bits
// - control bit 1 makes symbol 0 a burst with no pattern bits
// - control bit 6 picks the level of the symbol 1 burst
// - control bit 2 picks the level of the symbol 0 burst
// - symbol 0 pattern is upper byte at 4Dh joined with lower byte at 4Eh
// - a three-bit rate code picks the bit rate from 26 kHz to 848 kHz
package tsp_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SYM0_HI = 8'h4D;
  localparam logic [7:0] IDX_SYM0_LO = 8'h4E;
  localparam logic [7:0] IDX_SYM1_HI = 8'h4F;
  localparam logic [7:0] IDX_SYM1_LO = 8'h50;
  localparam logic [7:0] IDX_SYM2 = 8'h51;
  localparam logic [7:0] IDX_SYM3 = 8'h52;
  localparam logic [7:0] IDX_LEN10 = 8'h53;
  localparam logic [7:0] IDX_LEN32 = 8'h54;
  localparam logic [7:0] IDX_BURST_CTL = 8'h55;
  localparam logic [7:0] IDX_BURST_LEN = 8'h58;
  localparam logic [7:0] IDX_RATE = 8'h59;
  localparam logic [7:0] IDX_CMD = 8'h5A;
  // field positions
  localparam int SYM1_LEN_LSB = 4;
  localparam int SYM0_LEN_LSB = 0;
  localparam int SYM3_LEN_LSB = 4;
  localparam int SYM2_LEN_LSB = 0;
  localparam int SYM0_BURST_ON = 0;
  localparam int SYM0_BURST_ALONE = 1;
  localparam int SYM0_BURST_LEVEL = 2;
  localparam int SYM1_BURST_ON = 4;
  localparam int SYM1_BURST_ALONE = 5;
  localparam int SYM1_BURST_LEVEL = 6;
  localparam logic [7:0] LEN32_MASK = 8'h77;
  localparam logic [7:0] BURST_CTL_MASK = 8'h77;
  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_RATE = 3'h2;
  // bit rates in kHz and divider counts at the 10 MHz clock
  localparam int CLK_KHZ = 10000;
  localparam int RATE_26_KHZ = 26;
  localparam int RATE_53_KHZ = 53;
  localparam int RATE_106_KHZ = 106;
  localparam int RATE_212_KHZ = 212;
  localparam int RATE_242_KHZ = 242;
  localparam int RATE_848_KHZ = 848;
  localparam logic [9:0] DIV_26 = 10'(CLK_KHZ / RATE_26_KHZ);
  localparam logic [9:0] DIV_53 = 10'(CLK_KHZ / RATE_53_KHZ);
  localparam logic [9:0] DIV_106 = 10'(CLK_KHZ / RATE_106_KHZ);
  localparam logic [9:0] DIV_212 = 10'(CLK_KHZ / RATE_212_KHZ);
  localparam logic [9:0] DIV_242 = 10'(CLK_KHZ / RATE_242_KHZ);
  localparam logic [9:0] DIV_848 = 10'(CLK_KHZ / RATE_848_KHZ);
  // status bits of the command register
  localparam int STAT_BUSY = 0;
  localparam int STAT_FULL = 1;
  localparam int STAT_EMPTY = 2;
  localparam int FIFO_DEPTH = 4;
  localparam int SYM_W = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BURST = 2'b01,
    ST_PATTERN = 2'b10
  } tsp_state_t;
endpackage

// ==== logic/tsp_symbol_gen.sv ====
// register file and serialiser for the four programmable transmit symbols
`timescale 1ns/100ps
module tsp_symbol_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic tx_bit_o,
  output logic tx_strobe_o,
  output logic tx_busy_o
);
  import tsp_pkg::*;

  logic [7:0] sym_zero_upper_byte;
  logic [7:0] sym_zero_lower_byte;
  logic [7:0] sym_one_upper_byte;
  logic [7:0] sym_one_lower_byte;
  logic [7:0] symbol_two_pattern;
  logic [7:0] symbol_three_pattern;
  logic [7:0] symbols_zero_one_length;
  logic [7:0] symbols_two_three_length;
  logic [7:0] symbols_zero_one_burst_control;
  logic [7:0] burst_length_setting;
  logic [2:0] sym_zero_one_bit_rate;

  tsp_state_t state;
  logic [SYM_W-1:0] cur_sym;
  logic cur_alone;
  logic cur_level;
  logic [15:0] shreg;
  logic [8:0] bit_left;
  logic [9:0] div_cnt;
  logic from_burst;

  logic req;
  logic [7:0] idx;
  logic is_cmd_wr;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [SYM_W-1:0] fifo_data;
  logic emit;
  logic next_bit;

  // valid bit count of a symbol, field plus one
  function automatic logic [4:0] valid_count(input logic [SYM_W-1:0] s);
    case (s)
      2'h0: valid_count = {1'b0, symbols_zero_one_length[SYM0_LEN_LSB +: 4]} + 5'h01;
      2'h1: valid_count = {1'b0, symbols_zero_one_length[SYM1_LEN_LSB +: 4]} + 5'h01;
      2'h2: valid_count = {2'h0, symbols_two_three_length[SYM2_LEN_LSB +: 3]} + 5'h01;
      default: valid_count = {2'h0, symbols_two_three_length[SYM3_LEN_LSB +: 3]} + 5'h01;
    endcase
  endfunction

  // pattern shifted so that the top valid bit sits at bit 15
  function automatic logic [15:0] aligned_pattern(input logic [SYM_W-1:0] s);
    logic [15:0] raw;
    raw = 16'h0000;
    case (s)
      2'h0: raw = {sym_zero_upper_byte, sym_zero_lower_byte};
      2'h1: raw = {sym_one_upper_byte, sym_one_lower_byte};
      2'h2: raw = {8'h00, symbol_two_pattern};
      default: raw = {8'h00, symbol_three_pattern};
    endcase
    aligned_pattern = raw << (5'h10 - valid_count(s));
  endfunction

  // divider count for a rate code; the three lowest codes fall back to 26 kHz
  function automatic logic [9:0] rate_div(input logic [2:0] code);
    case (code)
      3'h3: rate_div = DIV_53;
      3'h4: rate_div = DIV_106;
      3'h5: rate_div = DIV_212;
      3'h6: rate_div = DIV_242;
      3'h7: rate_div = DIV_848;
      default: rate_div = DIV_26;
    endcase
  endfunction

  // bus decode; byte address is four times the register index
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = wb_adr_i[9:2];
  assign is_cmd_wr = wb_we_i && (idx == IDX_CMD) && wb_sel_i[0];

  // wishbone ack; a command write waits while the fifo is full
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && (!is_cmd_wr || fifo_in_ready);
    end
  end

  // register writes land on the acking edge; lane 0 carries the byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sym_zero_upper_byte <= RST_BYTE;
      sym_zero_lower_byte <= RST_BYTE;
      sym_one_upper_byte <= RST_BYTE;
      sym_one_lower_byte <= RST_BYTE;
      symbol_two_pattern <= RST_BYTE;
      symbol_three_pattern <= RST_BYTE;
      symbols_zero_one_length <= RST_BYTE;
      symbols_two_three_length <= RST_BYTE;
      symbols_zero_one_burst_control <= RST_BYTE;
      burst_length_setting <= RST_BYTE;
      sym_zero_one_bit_rate <= RST_RATE;
    end else if (req && wb_we_i && wb_sel_i[0]) begin
      case (idx)
        IDX_SYM0_HI: sym_zero_upper_byte <= wb_dat_i[7:0];
        IDX_SYM0_LO: sym_zero_lower_byte <= wb_dat_i[7:0];
        IDX_SYM1_HI: sym_one_upper_byte <= wb_dat_i[7:0];
        IDX_SYM1_LO: sym_one_lower_byte <= wb_dat_i[7:0];
        IDX_SYM2: symbol_two_pattern <= wb_dat_i[7:0];
        IDX_SYM3: symbol_three_pattern <= wb_dat_i[7:0];
        IDX_LEN10: symbols_zero_one_length <= wb_dat_i[7:0];
        IDX_LEN32: symbols_two_three_length <= wb_dat_i[7:0] & LEN32_MASK;
        IDX_BURST_CTL: symbols_zero_one_burst_control <= wb_dat_i[7:0] & BURST_CTL_MASK;
        IDX_BURST_LEN: burst_length_setting <= wb_dat_i[7:0];
        IDX_RATE: sym_zero_one_bit_rate <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  // read data; unmapped indices read as zero and still ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      case (idx)
        IDX_SYM0_HI: wb_dat_o <= {24'h000000, sym_zero_upper_byte};
        IDX_SYM0_LO: wb_dat_o <= {24'h000000, sym_zero_lower_byte};
        IDX_SYM1_HI: wb_dat_o <= {24'h000000, sym_one_upper_byte};
        IDX_SYM1_LO: wb_dat_o <= {24'h000000, sym_one_lower_byte};
        IDX_SYM2: wb_dat_o <= {24'h000000, symbol_two_pattern};
        IDX_SYM3: wb_dat_o <= {24'h000000, symbol_three_pattern};
        IDX_LEN10: wb_dat_o <= {24'h000000, symbols_zero_one_length};
        IDX_LEN32: wb_dat_o <= {24'h000000, symbols_two_three_length};
        IDX_BURST_CTL: wb_dat_o <= {24'h000000, symbols_zero_one_burst_control};
        IDX_BURST_LEN: wb_dat_o <= {24'h000000, burst_length_setting};
        IDX_RATE: wb_dat_o <= {29'h00000000, sym_zero_one_bit_rate};
        IDX_CMD: wb_dat_o <= {29'h00000000, !fifo_out_valid, !fifo_in_ready, tx_busy_o};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // queue of symbol numbers; software is stalled through ack when full
  tsp_fifo #(
    .WIDTH(SYM_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(req && is_cmd_wr),
    .in_ready_o(fifo_in_ready),
    .in_data_i(wb_dat_i[SYM_W-1:0]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(state == ST_IDLE),
    .out_data_o(fifo_data)
  );

  assign fifo_pop = fifo_out_valid && (state == ST_IDLE);
  // one bit goes out whenever the divider is at zero outside ST_IDLE
  assign emit = (state != ST_IDLE) && (div_cnt == 10'h000);
  assign next_bit = (state == ST_BURST) ? cur_level : shreg[15];

  // bit-time divider; keeps running down through idle so the last bit of a
  // symbol still lasts a full bit time before the next symbol starts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt <= 10'h000;
    end else if (emit) begin
      div_cnt <= rate_div(sym_zero_one_bit_rate) - 10'h001;
    end else if (div_cnt != 10'h000) begin
      div_cnt <= div_cnt - 10'h001;
    end
  end

  // symbol sequencer: burst first, then the valid pattern bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      cur_sym <= 2'h0;
      cur_alone <= 1'b0;
      cur_level <= 1'b0;
      shreg <= 16'h0000;
      bit_left <= 9'h000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (fifo_pop) begin
            cur_sym <= fifo_data;
            shreg <= aligned_pattern(fifo_data);
            if (fifo_data == 2'h0 && symbols_zero_one_burst_control[SYM0_BURST_ON]) begin
              state <= ST_BURST;
              cur_alone <= symbols_zero_one_burst_control[SYM0_BURST_ALONE];
              cur_level <= symbols_zero_one_burst_control[SYM0_BURST_LEVEL];
              bit_left <= {1'b0, burst_length_setting} + 9'h001;
            end else if (fifo_data == 2'h1
                         && symbols_zero_one_burst_control[SYM1_BURST_ON]) begin
              state <= ST_BURST;
              cur_alone <= symbols_zero_one_burst_control[SYM1_BURST_ALONE];
              cur_level <= symbols_zero_one_burst_control[SYM1_BURST_LEVEL];
              bit_left <= {1'b0, burst_length_setting} + 9'h001;
            end else begin
              state <= ST_PATTERN;
              cur_alone <= 1'b0;
              bit_left <= {4'h0, valid_count(fifo_data)};
            end
          end
        end
        ST_BURST: begin
          if (emit) begin
            bit_left <= bit_left - 9'h001;
            if (bit_left == 9'h001) begin
              if (cur_alone) begin
                state <= ST_IDLE;
              end else begin
                state <= ST_PATTERN;
                shreg <= aligned_pattern(cur_sym);
                bit_left <= {4'h0, valid_count(cur_sym)};
              end
            end
          end
        end
        ST_PATTERN: begin
          if (emit) begin
            shreg <= {shreg[14:0], 1'b0};
            bit_left <= bit_left - 9'h001;
            if (bit_left == 9'h001) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // serial output toward the modulator, one strobe per bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_bit_o <= 1'b0;
      tx_strobe_o <= 1'b0;
      from_burst <= 1'b0;
    end else begin
      tx_strobe_o <= emit;
      from_burst <= emit && (state == ST_BURST);
      if (emit) begin
        tx_bit_o <= next_bit;
      end
    end
  end

  // busy while a symbol is on air or still queued
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_busy_o <= 1'b0;
    end else begin
      tx_busy_o <= (state != ST_IDLE) || fifo_out_valid;
    end
  end

  // symbol 1 pattern start: count and top valid bit match the registers
  property p_sym1_load;
    @(posedge clk_i) disable iff (rst_i)
    (fifo_pop && fifo_data == 2'h1 && !symbols_zero_one_burst_control[SYM1_BURST_ON])
    |=> (bit_left == 9'(symbols_zero_one_length[7:4]) + 9'h001)
    && (shreg[15] == (symbols_zero_one_length[7]
                      ? sym_one_upper_byte[symbols_zero_one_length[6:4]]
                      : sym_one_lower_byte[symbols_zero_one_length[6:4]]));
  endproperty
  a_sym1_load: assert property (p_sym1_load) else $error("symbol 1 load wrong");

  property p_sym0_count;
    @(posedge clk_i) disable iff (rst_i)
    (fifo_pop && fifo_data == 2'h0 && !symbols_zero_one_burst_control[SYM0_BURST_ON])
    |=> bit_left == 9'(symbols_zero_one_length[3:0]) + 9'h001;
  endproperty
  a_sym0_count: assert property (p_sym0_count) else $error("symbol 0 count wrong");

  // symbol 0 pattern start: top valid bit from the upper or lower byte
  property p_sym0_top;
    @(posedge clk_i) disable iff (rst_i)
    (fifo_pop && fifo_data == 2'h0 && !symbols_zero_one_burst_control[SYM0_BURST_ON])
    |=> shreg[15] == (symbols_zero_one_length[3]
                      ? sym_zero_upper_byte[symbols_zero_one_length[2:0]]
                      : sym_zero_lower_byte[symbols_zero_one_length[2:0]]);
  endproperty
  a_sym0_top: assert property (p_sym0_top) else $error("symbol 0 top bit wrong");

  property p_sym2_count;
    @(posedge clk_i) disable iff (rst_i)
    (fifo_pop && fifo_data == 2'h2)
    |=> bit_left == 9'(symbols_two_three_length[2:0]) + 9'h001;
  endproperty
  a_sym2_count: assert property (p_sym2_count) else $error("symbol 2 count wrong");

  property p_sym2_top;
    @(posedge clk_i) disable iff (rst_i)
    (fifo_pop && fifo_data == 2'h2)
    |=> shreg[15] == symbol_two_pattern[symbols_two_three_length[2:0]];
  endproperty
  a_sym2_top: assert property (p_sym2_top) else $error("symbol 2 top bit wrong");

  property p_sym3_top;
    @(posedge clk_i) disable iff (rst_i)
    (fifo_pop && fifo_data == 2'h3)
    |=> (shreg[15] == symbol_three_pattern[symbols_two_three_length[6:4]])
    && (bit_left == 9'(symbols_two_three_length[6:4]) + 9'h001);
  endproperty
  a_sym3_top: assert property (p_sym3_top) else $error("symbol 3 load wrong");

  property p_burst_level;
    @(posedge clk_i) disable iff (rst_i)
    (tx_strobe_o && from_burst) |-> tx_bit_o == cur_level;
  endproperty
  a_burst_level: assert property (p_burst_level) else $error("burst level wrong");

  property p_alone_no_pattern;
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_BURST && cur_alone) |=> state != ST_PATTERN;
  endproperty
  a_alone_no_pattern: assert property (p_alone_no_pattern) else $error("pattern after lone burst");

  sequence s_burst_ends;
    $past(state) == ST_BURST && state != ST_BURST;
  endsequence
  property p_burst_then_pattern;
    @(posedge clk_i) disable iff (rst_i)
    (s_burst_ends ##0 !cur_alone) |-> state == ST_PATTERN;
  endproperty
  a_burst_then_pattern: assert property (p_burst_then_pattern) else $error("no pattern after burst");

  property p_bit_spacing;
    @(posedge clk_i) disable iff (rst_i)
    tx_strobe_o |=> !tx_strobe_o [*8];
  endproperty
  a_bit_spacing: assert property (p_bit_spacing) else $error("bits too close");

  property p_reserved_zero;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && (idx == IDX_LEN32 || idx == IDX_BURST_CTL))
    |=> wb_dat_o[7] == 1'b0 && wb_dat_o[3] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");
endmodule

// ==== tb/test_tsp_symbol_gen.sv ====
// self-checking bench for the transmit symbol pattern block
`timescale 1ns/100ps
module test_tsp_symbol_gen;
  import tsp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic tx_bit_o;
  logic tx_strobe_o;
  logic tx_busy_o;
  int bad_count = 0;
  int checks = 0;
  tsp_symbol_gen i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tx_bit_o(tx_bit_o), .tx_strobe_o(tx_strobe_o),
    .tx_busy_o(tx_busy_o));
  tsp_mod_model i_mod (.clk_i(clk_i), .rst_i(rst_i), .tx_bit_i(tx_bit_o),
    .tx_strobe_i(tx_strobe_o));
  // 100 ns period
  always #50 clk_i = ~clk_i;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", what, e, g);
      bad_count++;
    end
  endtask
  // one classic cycle; the ack is read as sampled at each edge
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 3000);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 3000) begin
      $display("BAD bus ack expected 1 seen timeout");
      bad_count++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, idx, d, 4'hF, q);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, 4'hF, q);
    chk(what, {24'h0, e}, q);
  endtask
  task automatic wait_idle();
    int k;
    repeat (3) @(posedge clk_i);
    for (k = 0; k < 5000 && tx_busy_o !== 1'b0; k++) @(posedge clk_i);
    if (k >= 5000) begin
      $display("BAD busy expected 0 seen timeout");
      bad_count++;
      stop_test();
    end
    // let the last strobe reach the model before its count is read
    repeat (2) @(posedge clk_i);
  endtask
  // queue one symbol and compare the captured bits against the expected stream
  task automatic send(input logic [1:0] s, input int n, input logic [31:0] e);
    int c0;
    logic [31:0] mask;
    c0 = i_mod.count;
    mask = (32'h1 << n) - 32'h1;
    wr(IDX_CMD, {6'h00, s});
    wait_idle();
    chk("bit count", 32'(n), 32'(i_mod.count - c0));
    chk("bit stream", e, i_mod.bits & mask);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic [7:0] idx[7] = '{IDX_SYM1_HI, IDX_SYM1_LO, IDX_SYM2, IDX_SYM3, IDX_LEN10,
                           IDX_LEN32, IDX_BURST_CTL};
    logic [7:0] rb[7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h77, 8'h77};
    for (int i = 0; i < 7; i++) rd_chk("reset value", idx[i], RST_BYTE);
    rd_chk("rate reset", IDX_RATE, {5'h00, RST_RATE});
    for (int i = 0; i < 7; i++) wr(idx[i], 8'hFF);
    for (int i = 0; i < 7; i++) rd_chk("readback", idx[i], rb[i]);
    wb(1'b1, IDX_SYM2, 8'h12, 4'h0, q);
    rd_chk("sel0 low write", IDX_SYM2, 8'hFF);
    wr(8'h60, 8'hAB);
    rd_chk("unmapped read", 8'h60, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_short();
    wr(IDX_SYM2, 8'hFD);
    wr(IDX_SYM3, 8'h96);
    wr(IDX_LEN32, 8'h72);
    send(2'd2, 3, 32'h5);
    send(2'd3, 8, 32'h96);
    $display("test short symbols done");
  endtask
  task automatic t_long();
    wr(IDX_BURST_CTL, 8'h00);
    wr(IDX_SYM0_HI, 8'hC3);
    wr(IDX_SYM0_LO, 8'h5A);
    wr(IDX_LEN10, 8'hFF);
    send(2'd0, 16, 32'hC35A);
    wr(IDX_SYM1_HI, 8'h81);
    wr(IDX_SYM1_LO, 8'h7E);
    send(2'd1, 16, 32'h817E);
    $display("test long symbols done");
  endtask
  task automatic t_burst();
    wr(IDX_SYM1_HI, 8'hFF);
    wr(IDX_SYM1_LO, 8'hFA);
    wr(IDX_SYM0_LO, 8'h01);
    wr(IDX_LEN10, 8'h20);
    wr(IDX_BURST_CTL, 8'h50);
    send(2'd1, 5, 32'h1A);
    wr(IDX_BURST_CTL, 8'h30);
    send(2'd1, 2, 32'h0);
    wr(IDX_BURST_CTL, 8'h07);
    send(2'd0, 2, 32'h3);
    wr(IDX_BURST_CTL, 8'h01);
    send(2'd0, 3, 32'h1);
    $display("test burst done");
  endtask
  // six queued writes: the last must wait for a free slot
  task automatic t_fifo();
    int c0;
    c0 = i_mod.count;
    wr(IDX_BURST_CTL, 8'h00);
    for (int i = 0; i < 6; i++) wr(IDX_CMD, 8'h02);
    rd_chk("status full", IDX_CMD, 8'h03);
    wait_idle();
    chk("queued count", 32'd18, 32'(i_mod.count - c0));
    chk("queued stream", 32'h2DB6D, i_mod.bits & 32'h3FFFF);
    rd_chk("status empty", IDX_CMD, 8'h04);
    $display("test fifo done");
  endtask
  // cycles between the first two strobes of a symbol 2 at one rate code
  task automatic rate_gap(input logic [7:0] code, input logic [9:0] e);
    int k;
    wr(IDX_RATE, code);
    wr(IDX_CMD, 8'h02);
    for (k = 0; k < 1000 && tx_strobe_o !== 1'b1; k++) @(posedge clk_i);
    @(posedge clk_i);
    for (k = 1; k < 1000 && tx_strobe_o !== 1'b1; k++) @(posedge clk_i);
    chk("bit spacing", {22'h0, e}, 32'(k));
    wait_idle();
  endtask
  task automatic t_rate();
    rate_gap(8'h06, DIV_242);
    rate_gap(8'h05, DIV_212);
    rate_gap(8'h04, DIV_106);
    rate_gap(8'h03, DIV_53);
    rate_gap(8'h00, DIV_26);
    $display("test rate done");
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    wr(IDX_RATE, 8'h07);
    wr(IDX_BURST_LEN, 8'h01);
    t_short();
    t_long();
    t_burst();
    t_fifo();
    t_rate();
    stop_test();
  end
endmodule

// ==== tb/tsp_mod_model.sv ====
// modulator model: captures each bit handed over on the strobe
`timescale 1ns/100ps
module tsp_mod_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tx_bit_i,
  input wire logic tx_strobe_i
);
  logic [31:0] bits;
  int count;
  // shift in at each strobe; newest bit lands in bit 0 so arrival order is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bits <= 32'h0;
      count <= 0;
    end else if (tx_strobe_i) begin
      bits <= {bits[30:0], tx_bit_i};
      count <= count + 1;
    end
  end
endmodule
